/* File: src/mmbs_slave.sv */
// Modbus RTU slave serving the meter holding registers, plus output clamps
`timescale 1ns/10ps
`include "mmbs_regs.svh"
// How it works
// - Start bit, eight data bits, stops, no parity
// - Send two stops, accept one or two
// - Link rate selectable from 1200 to 115200
// - Values served as two's complement holding registers
// - Function 03h reads one or more registers
// - Functions 06h and 10h write registers
// - Groups limited to sixteen registers
// - Broadcast requests executed, never answered
// - Measured value high and low words, read-only
// - Status reads 0h, A0h or 60h
// - Relays in bits 0,1, alarm bit 4
// - Writes drive relays from bits 0,1 only
// - Active current setpoint 0h to 1800h
// - Passive current setpoint 2CCh to 1800h
// - Voltage setpoint 0h to 1600h
// - Peak value high and low words, read-only
// - Input range select, values 0 to 5
// - Decimal point position 0 to 3, writable
// - Negative input under square root shows low scale
// - Out-of-table input uses first or last segment
// - Output above working range clamps to border
// - Rate code 0..7 picks the baud rate
// - Write permission gates all register writes
module mmbs_slave #(
	parameter int MCLK_HZ = 10000000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Serial link
	input wire logic rxd,
	output logic txd,
	output logic tx_en,
	// Link settings
	input wire logic [7:0] slave_addr,
	input wire logic [2:0] baud_sel,
	input wire logic remote_write_permit,
	input wire mmbs_pkg::mmbs_kind_t out_kind,
	// Measurement state
	input wire logic [31:0] meas_value,
	input wire logic meas_over,
	input wire logic meas_under,
	input wire logic alarm_on,
	input wire logic [31:0] peak_value,
	// Controls set over the link
	output logic relay_first,
	output logic relay_second,
	output logic [1:0] dp_pos,
	output logic [15:0] ao_setpoint,
	output logic [2:0] range_sel,
	// Display conversion
	input wire logic char_sqrt,
	input wire logic norm_negative,
	input wire logic [31:0] root_value,
	input wire logic [31:0] scale_low_value,
	output logic [31:0] disp_value,
	// User table segment choice
	input wire logic signed [15:0] norm_x,
	input wire logic signed [15:0] first_x,
	input wire logic signed [15:0] last_x,
	input wire logic [4:0] point_count,
	input wire logic [4:0] seg_raw,
	output logic [4:0] seg_sel,
	// Analogue output clamp
	input wire logic [15:0] ao_computed,
	input wire logic [15:0] ao_upper_border,
	output logic [15:0] ao_drive
);
	import mmbs_pkg::*;

	function automatic logic [15:0] bit_div(input logic [2:0] sel);
		logic [31:0] rate;
		case (sel)
			3'h0: rate = `MMBS_BAUD_0;
			3'h1: rate = `MMBS_BAUD_1;
			3'h2: rate = `MMBS_BAUD_2;
			3'h3: rate = `MMBS_BAUD_3;
			3'h4: rate = `MMBS_BAUD_4;
			3'h5: rate = `MMBS_BAUD_5;
			3'h6: rate = `MMBS_BAUD_6;
			default: rate = `MMBS_BAUD_7;
		endcase
		return 16'((32'(MCLK_HZ) + rate / 32'h2) / rate);
	endfunction

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ `MMBS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	logic rx_s1_q, rx_s2_q;
	mmbs_rx_t rx_st_q;
	logic [15:0] rx_cnt_q;
	logic [2:0] rx_bit_q;
	logic [7:0] rx_sh_q, prev_q;
	logic rx_done_q, rx_ferr_q;
	logic [15:0] gap_cnt_q;
	logic [5:0] gap_bits_q;
	logic [5:0] fr_len_q;
	logic fr_bad_q;
	logic [15:0] fr_crc_q, fr_start_q, fr_qty_q;
	logic [7:0] fr_addr_q, fr_func_q, fr_bc_q;
	mmbs_state_t st_q;
	logic [7:0] exc_q;
	logic bcast_q;
	logic [4:0] wi_q;
	logic [5:0] tx_idx_q;
	logic [15:0] txc_q, tx_cnt_q;
	logic [10:0] tx_sh_q;
	logic [3:0] tx_bits_q;
	logic [1:0] relay_q, dp_q;
	logic [15:0] set_q;
	logic [2:0] range_q;
	logic [15:0] mem_rdata;

	// Receiver
	wire logic [15:0] div_w = bit_div(baud_sel);
	wire logic [15:0] div_last = div_w - 16'h0001;
	wire logic rx_tick = (rx_cnt_q == 16'h0000);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= rxd;
			rx_s2_q <= rx_s1_q;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= 16'h0000;
			rx_bit_q <= 3'h0;
			rx_sh_q <= 8'h00;
			rx_done_q <= 1'b0;
			rx_ferr_q <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			if (rx_st_q != RX_IDLE && !rx_tick) begin
				rx_cnt_q <= rx_cnt_q - 16'h0001;
			end
			case (rx_st_q)
				RX_IDLE: begin
					if (!rx_s2_q) begin
						rx_st_q <= RX_START;
						rx_cnt_q <= div_w >> 1;
					end
				end
				RX_START: begin
					if (rx_tick) begin
						rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
						rx_cnt_q <= div_last;
						rx_bit_q <= 3'h0;
					end
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						rx_cnt_q <= div_last;
						if (rx_bit_q == 3'h7) begin
							rx_st_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					// A second stop bit simply looks like idle line
					if (rx_tick) begin
						rx_st_q <= RX_IDLE;
						rx_done_q <= 1'b1;
						rx_ferr_q <= !rx_s2_q;
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// Frame end after 3.5 characters of silence
	wire logic line_idle = (rx_st_q == RX_IDLE) && rx_s2_q;
	wire logic gap_wrap = (gap_cnt_q == div_last);
	wire logic frame_end = line_idle && gap_wrap && (gap_bits_q == `MMBS_GAP_BITS - 6'h01) && (fr_len_q != 6'h00);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gap_cnt_q <= 16'h0000;
			gap_bits_q <= 6'h00;
		end else if (!line_idle) begin
			gap_cnt_q <= 16'h0000;
			gap_bits_q <= 6'h00;
		end else begin
			gap_cnt_q <= gap_wrap ? 16'h0000 : gap_cnt_q + 16'h0001;
			if (gap_wrap && gap_bits_q != `MMBS_GAP_BITS) begin
				gap_bits_q <= gap_bits_q + 6'h01;
			end
		end
	end

	// Request parsing; byte 4 of a single write lands in the quantity field
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fr_len_q <= 6'h00;
			fr_bad_q <= 1'b0;
			fr_crc_q <= `MMBS_CRC_INIT;
			fr_addr_q <= 8'h00;
			fr_func_q <= 8'h00;
			fr_start_q <= 16'h0000;
			fr_qty_q <= 16'h0000;
			fr_bc_q <= 8'h00;
			prev_q <= 8'h00;
		end else if (frame_end) begin
			fr_len_q <= 6'h00;
			fr_bad_q <= 1'b0;
			fr_crc_q <= `MMBS_CRC_INIT;
		end else if (rx_done_q) begin
			prev_q <= rx_sh_q;
			fr_crc_q <= crc_byte(fr_crc_q, rx_sh_q);
			if (rx_ferr_q || fr_len_q == `MMBS_MAX_FRAME) begin
				fr_bad_q <= 1'b1;
			end
			if (fr_len_q != `MMBS_MAX_FRAME) begin
				fr_len_q <= fr_len_q + 6'h01;
			end
			case (fr_len_q)
				6'h00: fr_addr_q <= rx_sh_q;
				6'h01: fr_func_q <= rx_sh_q;
				6'h02: fr_start_q[15:8] <= rx_sh_q;
				6'h03: fr_start_q[7:0] <= rx_sh_q;
				6'h04: fr_qty_q[15:8] <= rx_sh_q;
				6'h05: fr_qty_q[7:0] <= rx_sh_q;
				6'h06: fr_bc_q <= rx_sh_q;
				default: fr_bc_q <= fr_bc_q;
			endcase
		end
	end

	wire logic fn_rd = (fr_func_q == `MMBS_FN_READ);
	wire logic fn_w1 = (fr_func_q == `MMBS_FN_WRITE1);
	wire logic fn_wn = (fr_func_q == `MMBS_FN_WRITEN);
	wire logic [15:0] qty_w = fn_w1 ? 16'h0001 : fr_qty_q;
	wire logic len_ok = fn_wn ? ({2'h0, fr_len_q} == fr_bc_q + 8'h09) : (fn_rd || fn_w1) ? (fr_len_q == 6'h08) : 1'b1;
	wire logic for_us = (fr_addr_q == slave_addr) || (fr_addr_q == `MMBS_BCAST);
	// Checksum over the whole frame, check bytes included, leaves zero
	wire logic frame_ok = frame_end && (st_q == ST_IDLE) && !fr_bad_q && (fr_crc_q == 16'h0000) &&
		(fr_len_q >= 6'h04) && len_ok && for_us;

	// Group data words kept until the checksum is known good
	wire logic mem_we = rx_done_q && (st_q == ST_IDLE) &&
		((fn_w1 && fr_len_q == 6'h05) || (fn_wn && fr_len_q >= 6'h08 && !fr_len_q[0] && fr_len_q <= 6'h27));
	wire logic [5:0] mem_off = fr_len_q - 6'h08;
	wire logic [3:0] mem_waddr = fn_w1 ? 4'h0 : mem_off[4:1];
	wire logic [3:0] mem_raddr = (st_q == ST_TX) ? 4'h0 : wi_q[3:0];

	mmbs_word_mem #(.WIDTH(16), .DEPTH(16), .AW(4)) u_mem (
		.mclk(mclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata({prev_q, rx_sh_q}),
		.raddr(mem_raddr),
		.rdata(mem_rdata)
	);

	// Request
	wire logic [16:0] grp_end = {1'b0, fr_start_q} + {1'b0, qty_w} - 17'h00001;
	wire logic [15:0] ge = grp_end[15:0];
	wire logic rd_map_ok = !grp_end[16] && (
		(fr_start_q >= `MMBS_REG_MEAS_HI && ge <= `MMBS_REG_SETPOINT) ||
		(fr_start_q >= `MMBS_REG_PEAK_HI && ge <= `MMBS_REG_PEAK_LO) ||
		(fr_start_q == `MMBS_REG_RANGE && ge == `MMBS_REG_RANGE));
	wire logic wr_map_ok = !grp_end[16] && (
		(fr_start_q >= `MMBS_REG_DP && ge <= `MMBS_REG_SETPOINT) ||
		(fr_start_q == `MMBS_REG_RANGE && ge == `MMBS_REG_RANGE));
	wire logic qty_bad = (qty_w == 16'h0000) || (qty_w > `MMBS_MAX_GROUP) || (fn_wn && fr_bc_q != {qty_w[6:0], 1'b0});
	wire logic [7:0] exc_w = !(fn_rd || fn_w1 || fn_wn) ? `MMBS_EXC_FUNC :
		(!fn_rd && !remote_write_permit) ? `MMBS_EXC_FUNC :
		qty_bad ? `MMBS_EXC_VALUE :
		(fn_rd ? !rd_map_ok : !wr_map_ok) ? `MMBS_EXC_ADDR : 8'h00;

	// Register write path; values outside the range are refused
	wire logic [15:0] wr_addr = fr_start_q + {11'h000, wi_q};
	wire logic [15:0] set_lo = (out_kind == `MMBS_KIND_PASSIVE) ? `MMBS_SET_MIN_PAS : 16'h0000;
	wire logic [15:0] set_hi = (out_kind == `MMBS_KIND_VOLT) ? `MMBS_SET_MAX_VOLT : `MMBS_SET_MAX_CUR;
	wire logic val_ok = (wr_addr == `MMBS_REG_DP) ? (mem_rdata <= `MMBS_DP_MAX) :
		(wr_addr == `MMBS_REG_SETPOINT) ? (mem_rdata >= set_lo && mem_rdata <= set_hi) :
		(wr_addr == `MMBS_REG_RANGE) ? (mem_rdata <= `MMBS_RANGE_MAX) : 1'b1;
	wire logic wr_en = (st_q == ST_WPUT) && val_ok;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			relay_q <= 2'h0;
			dp_q <= 2'h0;
			set_q <= 16'h0000;
			range_q <= 3'h0;
		end else if (wr_en) begin
			case (wr_addr)
				`MMBS_REG_DP: dp_q <= mem_rdata[1:0];
				`MMBS_REG_RELAY: relay_q <= mem_rdata[1:0];
				`MMBS_REG_SETPOINT: set_q <= mem_rdata;
				`MMBS_REG_RANGE: range_q <= mem_rdata[2:0];
				default: relay_q <= relay_q;
			endcase
		end
	end

	// Register read path
	wire logic [5:0] rd_off = tx_idx_q - 6'h03;
	wire logic [15:0] rd_addr = fr_start_q + {11'h000, rd_off[5:1]};
	wire logic [15:0] status_w = meas_over ? `MMBS_STAT_OVER : meas_under ? `MMBS_STAT_UNDER : `MMBS_STAT_OK;
	wire logic [15:0] relay_w = {11'h000, alarm_on, 2'h0, relay_q[`MMBS_BIT_RELAY2], relay_q[`MMBS_BIT_RELAY1]};
	wire logic [15:0] rd_word = (rd_addr == `MMBS_REG_MEAS_HI) ? meas_value[31:16] :
		(rd_addr == `MMBS_REG_MEAS_LO) ? meas_value[15:0] :
		(rd_addr == `MMBS_REG_STATUS) ? status_w :
		(rd_addr == `MMBS_REG_DP) ? {14'h0000, dp_q} :
		(rd_addr == `MMBS_REG_RELAY) ? relay_w :
		(rd_addr == `MMBS_REG_SETPOINT) ? set_q :
		(rd_addr == `MMBS_REG_PEAK_HI) ? peak_value[31:16] :
		(rd_addr == `MMBS_REG_PEAK_LO) ? peak_value[15:0] :
		(rd_addr == `MMBS_REG_RANGE) ? {13'h0000, range_q} : 16'h0000;

	// Response bytes
	wire logic is_exc = (exc_q != 8'h00);
	wire logic [5:0] tx_len = is_exc ? 6'h03 : fn_rd ? 6'h03 + {qty_w[4:0], 1'b0} : 6'h06;
	wire logic [15:0] echo_w = fn_w1 ? mem_rdata : qty_w;
	wire logic [7:0] pay_b = (tx_idx_q == 6'h00) ? fr_addr_q :
		(tx_idx_q == 6'h01) ? (is_exc ? (fr_func_q | `MMBS_FN_EXC) : fr_func_q) :
		(tx_idx_q == 6'h02) ? (is_exc ? exc_q : fn_rd ? {qty_w[6:0], 1'b0} : fr_start_q[15:8]) :
		fn_rd ? (tx_idx_q[0] ? rd_word[15:8] : rd_word[7:0]) :
		(tx_idx_q == 6'h03) ? fr_start_q[7:0] :
		(tx_idx_q == 6'h04) ? echo_w[15:8] : echo_w[7:0];
	wire logic [7:0] tx_byte = (tx_idx_q < tx_len) ? pay_b : (tx_idx_q == tx_len) ? txc_q[7:0] : txc_q[15:8];
	wire logic tx_busy = (tx_bits_q != 4'h0);
	wire logic tx_fin = (tx_idx_q == tx_len + 6'h02);
	wire logic tx_load = (st_q == ST_TX) && !tx_busy && !tx_fin;

	// Two stop bits on every character sent
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tx_sh_q <= 11'h7FF;
			tx_bits_q <= 4'h0;
			tx_cnt_q <= 16'h0000;
		end else if (tx_load) begin
			tx_sh_q <= {2'b11, tx_byte, 1'b0};
			tx_bits_q <= `MMBS_TX_BITS;
			tx_cnt_q <= div_last;
		end else if (tx_busy) begin
			tx_cnt_q <= (tx_cnt_q == 16'h0000) ? div_last : tx_cnt_q - 16'h0001;
			if (tx_cnt_q == 16'h0000) begin
				tx_sh_q <= {1'b1, tx_sh_q[10:1]};
				tx_bits_q <= tx_bits_q - 4'h1;
			end
		end
	end

	// Request sequencing
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_IDLE;
			exc_q <= 8'h00;
			bcast_q <= 1'b0;
			wi_q <= 5'h00;
			tx_idx_q <= 6'h00;
			txc_q <= `MMBS_CRC_INIT;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (frame_ok) begin
						st_q <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					exc_q <= exc_w;
					bcast_q <= (fr_addr_q == `MMBS_BCAST);
					wi_q <= 5'h00;
					tx_idx_q <= 6'h00;
					txc_q <= `MMBS_CRC_INIT;
					if (exc_w == 8'h00 && !fn_rd) begin
						st_q <= ST_WRD;
					end else begin
						st_q <= (fr_addr_q == `MMBS_BCAST) ? ST_IDLE : ST_TX;
					end
				end
				ST_WRD: st_q <= ST_WPUT;
				ST_WPUT: begin
					if (!val_ok) begin
						exc_q <= `MMBS_EXC_VALUE;
					end
					wi_q <= wi_q + 5'h01;
					if ({11'h000, wi_q} == qty_w - 16'h0001) begin
						st_q <= bcast_q ? ST_IDLE : ST_TX;
					end else begin
						st_q <= ST_WRD;
					end
				end
				ST_TX: begin
					if (tx_load) begin
						tx_idx_q <= tx_idx_q + 6'h01;
						if (tx_idx_q < tx_len) begin
							txc_q <= crc_byte(txc_q, pay_b);
						end
					end
					if (tx_fin && !tx_busy) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Display and output conversion clamps
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			disp_value <= 32'h00000000;
			seg_sel <= 5'h00;
			ao_drive <= 16'h0000;
		end else begin
			disp_value <= (char_sqrt && norm_negative) ? scale_low_value : root_value;
			seg_sel <= (norm_x < first_x) ? 5'h00 : (norm_x > last_x) ? point_count - 5'h02 : seg_raw;
			ao_drive <= (ao_computed > ao_upper_border) ? ao_upper_border : ao_computed;
		end
	end

	assign txd = tx_sh_q[0];
	assign tx_en = (st_q == ST_TX);
	assign relay_first = relay_q[`MMBS_BIT_RELAY1];
	assign relay_second = relay_q[`MMBS_BIT_RELAY2];
	assign dp_pos = dp_q;
	assign ao_setpoint = set_q;
	assign range_sel = range_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_relay_follow: assert property ((wr_en && wr_addr == `MMBS_REG_RELAY) |=>
		(relay_first == $past(mem_rdata[0]) && relay_second == $past(mem_rdata[1])))
		else $error("relays do not follow written bits");
	a_alarm_bit: assert property ((rd_addr == `MMBS_REG_RELAY) |-> (rd_word[4] == alarm_on && rd_word[15:5] == 11'h000))
		else $error("alarm bit wrong in relay word");
	a_status_over: assert property ((rd_addr == `MMBS_REG_STATUS && meas_over) |-> rd_word == `MMBS_STAT_OVER)
		else $error("over-range status code wrong");
	a_meas_words: assert property ((rd_addr == `MMBS_REG_MEAS_LO) |-> rd_word == meas_value[15:0])
		else $error("measured low word wrong");
	a_passive_min: assert property ((st_q == ST_WPUT && wr_addr == `MMBS_REG_SETPOINT &&
		out_kind == `MMBS_KIND_PASSIVE && mem_rdata < `MMBS_SET_MIN_PAS) |=> $stable(ao_setpoint))
		else $error("passive setpoint below floor taken");
	a_bcast_quiet: assert property ((st_q == ST_CHECK && fr_addr_q == `MMBS_BCAST) |=> !tx_en [*8])
		else $error("broadcast answered");
	a_write_permit: assert property ($changed(dp_pos) |-> $past(remote_write_permit))
		else $error("write without permission");
	a_group_max: assert property ((st_q == ST_CHECK && qty_w > `MMBS_MAX_GROUP &&
		(fn_rd || (fn_wn && remote_write_permit))) |=> exc_q == `MMBS_EXC_VALUE)
		else $error("oversized group not refused");
	// Sampled reset keeps the release cycle, still flushing reset values, out of the check
	a_sqrt_low: assert property ((char_sqrt && norm_negative && arst_n) |=>
		disp_value == $past(scale_low_value))
		else $error("negative root input not clamped");
	a_ao_clamp: assert property ((ao_computed > ao_upper_border) |=> ao_drive == $past(ao_upper_border))
		else $error("output not held at upper border");
	a_tx_idle: assert property ((st_q == ST_IDLE) |-> txd)
		else $error("line not idle high");

	c_read_reply: cover property ((st_q == ST_CHECK && fn_rd && exc_w == 8'h00) ##1 tx_en);
	c_single_write: cover property (wr_en && fn_w1);
	c_group_write: cover property (wr_en && fn_wn && wi_q == 5'h01);
	c_exception: cover property (tx_en && is_exc);
endmodule

/* File: src/mmbs_regs.svh */
// Offsets, field positions, limits and timing figures of the meter Modbus slave
`ifndef MMBS_REGS_SVH
`define MMBS_REGS_SVH
`define MMBS_REG_MEAS_HI 16'h0001
`define MMBS_REG_MEAS_LO 16'h0002
`define MMBS_REG_STATUS 16'h0003
`define MMBS_REG_DP 16'h0004
`define MMBS_REG_RELAY 16'h0005
`define MMBS_REG_SETPOINT 16'h0006
`define MMBS_REG_PEAK_HI 16'h0008
`define MMBS_REG_PEAK_LO 16'h0009
`define MMBS_REG_RANGE 16'h0010
`define MMBS_BIT_RELAY1 0
`define MMBS_BIT_RELAY2 1
`define MMBS_BIT_ALARM 4
`define MMBS_STAT_OK 16'h0000
`define MMBS_STAT_OVER 16'h00A0
`define MMBS_STAT_UNDER 16'h0060
`define MMBS_DP_MAX 16'h0003
`define MMBS_RANGE_MAX 16'h0005
`define MMBS_SET_MAX_CUR 16'h1800
`define MMBS_SET_MIN_PAS 16'h02CC
`define MMBS_SET_MAX_VOLT 16'h1600
`define MMBS_KIND_ACTIVE 2'h0
`define MMBS_KIND_PASSIVE 2'h1
`define MMBS_KIND_VOLT 2'h2
`define MMBS_FN_READ 8'h03
`define MMBS_FN_WRITE1 8'h06
`define MMBS_FN_WRITEN 8'h10
`define MMBS_FN_EXC 8'h80
`define MMBS_EXC_FUNC 8'h01
`define MMBS_EXC_ADDR 8'h02
`define MMBS_EXC_VALUE 8'h03
`define MMBS_MAX_GROUP 16'h0010
`define MMBS_BCAST 8'h00
`define MMBS_MAX_FRAME 6'h29
`define MMBS_CRC_INIT 16'hFFFF
`define MMBS_CRC_POLY 16'hA001
`define MMBS_TX_BITS 4'hB
`define MMBS_GAP_BITS 6'h27
`define MMBS_BAUD_0 32'h000004B0
`define MMBS_BAUD_1 32'h00000960
`define MMBS_BAUD_2 32'h000012C0
`define MMBS_BAUD_3 32'h00002580
`define MMBS_BAUD_4 32'h00004B00
`define MMBS_BAUD_5 32'h00009600
`define MMBS_BAUD_6 32'h0000E100
`define MMBS_BAUD_7 32'h0001C200
`endif

/* File: src/mmbs_pkg.sv */
// Types shared by the meter Modbus slave
package mmbs_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mmbs_rx_t;
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_WRD, ST_WPUT, ST_TX} mmbs_state_t;
	typedef logic [1:0] mmbs_kind_t;
endpackage

/* File: src/mmbs_word_mem.sv */
// Small word store for the data words of a single or group write
`timescale 1ns/10ps
module mmbs_word_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock
	input wire logic mclk,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
		rdata <= mem_q[raddr];
	end
endmodule

/* File: sim/mmbs_master.sv */
// Modbus RTU master model driving the slave serial link
`timescale 1ns/10ps
module mmbs_master (
	// Link
	input wire logic mclk,
	output logic rxd,
	input wire logic txd,
	input wire logic tx_en,
	// Bit time in clocks and stop bits sent
	input wire logic [7:0] bit_cyc,
	input wire logic [1:0] stops
);
	initial rxd = 1'b1;
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	task automatic bit_out(input logic v);
		rxd <= v;
		repeat (bit_cyc) @(posedge mclk);
	endtask
	// Silence first so the slave sees a fresh frame; bad flips the lowest checksum bit
	task automatic send(input logic [7:0] q[$], input logic bad);
		logic [15:0] c;
		repeat (40 * bit_cyc) @(posedge mclk);
		c = crc(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (q[i]) begin
			bit_out(1'b0);
			for (int b = 0; b < 8; b++) bit_out(q[i][b]);
			repeat (stops) bit_out(1'b1);
		end
	endtask
	// Empty reply when the slave stays silent
	task automatic recv(output logic [7:0] q[$], output logic ok);
		logic [7:0] b;
		int t;
		q = {};
		ok = 1'b1;
		t = 0;
		while (tx_en !== 1'b1 && t < 2000) begin
			@(posedge mclk);
			t++;
		end
		while (tx_en === 1'b1) begin
			if (txd === 1'b0) begin
				repeat (bit_cyc / 2) @(posedge mclk);
				for (int i = 0; i < 10; i++) begin
					repeat (bit_cyc) @(posedge mclk);
					if (i < 8) b[i] = txd;
					else ok &= txd;
				end
				q.push_back(b);
			end else @(posedge mclk);
		end
		if (q.size() > 1) ok &= (crc(q) === 16'h0000);
	endtask
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the meter Modbus slave
`timescale 1ns/10ps
module testbench;
	import mmbs_pkg::*;
	typedef struct {logic ov; logic un; logic [7:0] a; logic [7:0] ex; logic [15:0] w;} mmbs_row_t;
	logic mclk = 1'b0, arst_n = 1'b0, rxd, txd, tx_en, wp = 1'b1, ov = 1'b0, un = 1'b0, al = 1'b1;
	logic sq = 1'b1, neg = 1'b1, relay_first, relay_second;
	logic [7:0] sa = 8'h2A;
	logic [2:0] baud = 3'h7, range_sel;
	logic [1:0] stops = 2'h1, dp_pos;
	mmbs_kind_t kind = 2'h0;
	logic [15:0] ao_set, ao_c = 16'h0000, ao_drive, ub = 16'h1500;
	logic [31:0] meas = 32'hFFFFFF85, peak = 32'h00012345, lo = 32'hFFFFFED4, root = 32'h00000267, disp;
	logic signed [15:0] nx = 16'sh0000;
	logic [4:0] seg;
	logic [7:0] r[$];
	logic [15:0] okv[3] = '{16'h1800, 16'h02CC, 16'h1600}, badv[3] = '{16'h1801, 16'h02CB, 16'h1601};
	int miscompares = 0, n_checks = 0;
	// Bit time follows rate codes 7 and 6 with MCLK_HZ lowered to 576000
	wire logic [7:0] bit_cyc = (baud == 3'h7) ? 8'h05 : 8'h0A;
	mmbs_row_t rows[13] = '{
		'{1'h0, 1'h0, 8'h01, 8'h00, 16'hFFFF},
		'{1'h0, 1'h0, 8'h02, 8'h00, 16'hFF85},
		'{1'h0, 1'h0, 8'h03, 8'h00, 16'h0000},
		'{1'h1, 1'h0, 8'h03, 8'h00, 16'h00A0},
		'{1'h0, 1'h1, 8'h03, 8'h00, 16'h0060},
		'{1'h0, 1'h0, 8'h04, 8'h00, 16'h0000},
		'{1'h0, 1'h0, 8'h05, 8'h00, 16'h0010},
		'{1'h0, 1'h0, 8'h06, 8'h00, 16'h0000},
		'{1'h0, 1'h0, 8'h07, 8'h02, 16'h0000},
		'{1'h0, 1'h0, 8'h08, 8'h00, 16'h0001},
		'{1'h0, 1'h0, 8'h09, 8'h00, 16'h2345},
		'{1'h0, 1'h0, 8'h0A, 8'h02, 16'h0000},
		'{1'h0, 1'h0, 8'h10, 8'h00, 16'h0000}};
	mmbs_slave #(.MCLK_HZ(576000)) dut (.mclk(mclk), .arst_n(arst_n), .rxd(rxd), .txd(txd), .tx_en(tx_en),
		.slave_addr(sa), .baud_sel(baud), .remote_write_permit(wp), .out_kind(kind), .meas_value(meas),
		.meas_over(ov), .meas_under(un), .alarm_on(al), .peak_value(peak), .relay_first(relay_first),
		.relay_second(relay_second), .dp_pos(dp_pos), .ao_setpoint(ao_set), .range_sel(range_sel),
		.char_sqrt(sq), .norm_negative(neg), .root_value(root), .scale_low_value(lo), .disp_value(disp),
		.norm_x(nx), .first_x(16'sh0000), .last_x(16'sh0064), .point_count(5'h0B), .seg_raw(5'h05),
		.seg_sel(seg), .ao_computed(ao_c), .ao_upper_border(ub), .ao_drive(ao_drive));
	mmbs_master m (.mclk(mclk), .rxd(rxd), .txd(txd), .tx_en(tx_en), .bit_cyc(bit_cyc), .stops(stops));
	always #50 mclk = ~mclk;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	task automatic xact(input logic [7:0] q[$], input logic bad, input int n);
		logic ok;
		m.send(q, bad);
		m.recv(r, ok);
		chk("reply_len", n, r.size());
		if (n > 0) chk("reply_frame", 1, {31'h0, ok});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] n_reg, input int n);
		xact({sa, 8'h03, 8'h00, a, 8'h00, n_reg}, 1'b0, n);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] v, input int n);
		xact({sa, 8'h06, 8'h00, a, v[15:8], v[7:0]}, 1'b0, n);
	endtask
	task automatic cv(input logic ng, input logic signed [15:0] x, input logic [15:0] a,
		input logic [31:0] d, input logic [4:0] s, input logic [15:0] o);
		neg <= ng;
		nx <= x;
		ao_c <= a;
		repeat (2) @(posedge mclk);
		chk("disp", d, disp);
		chk("seg", {27'h0, s}, {27'h0, seg});
		chk("ao_drive", {16'h0, o}, {16'h0, ao_drive});
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk("reset", 25'h1000000, {txd, tx_en, relay_first, relay_second, dp_pos, range_sel, ao_set});
		foreach (rows[i]) begin
			ov <= rows[i].ov;
			un <= rows[i].un;
			rd(rows[i].a, 8'h01, (rows[i].ex !== 8'h00) ? 5 : 7);
			if (rows[i].ex !== 8'h00) chk("exc", {8'h83, rows[i].ex}, {r[1], r[2]});
			else chk("rd_word", rows[i].w, {r[3], r[4]});
		end
		wr(8'h05, 16'hFFF2, 8);
		chk("relays", 2'h2, {relay_second, relay_first});
		rd(8'h05, 8'h01, 7);
		chk("relay_reg", 16'h0012, {r[3], r[4]});
		wr(8'h01, 16'h0000, 5);
		chk("ro_exc", 16'h8602, {r[1], r[2]});
		wr(8'h04, 16'h0003, 8);
		wr(8'h04, 16'h0004, 5);
		chk("dp", 2'h3, dp_pos);
		for (int k = 0; k < 3; k++) begin
			kind <= k[1:0];
			wr(8'h06, okv[k], 8);
			wr(8'h06, badv[k], 5);
			chk("setpoint", okv[k], ao_set);
		end
		wr(8'h10, 16'h0005, 8);
		wr(8'h10, 16'h0006, 5);
		chk("range", 3'h5, range_sel);
		xact({sa, 8'h10, 8'h00, 8'h04, 8'h00, 8'h03, 8'h06, 8'h00, 8'h02, 8'h00, 8'h01, 8'h12, 8'h00}, 1'b0, 8);
		rd(8'h04, 8'h03, 11);
		chk("grp_rd", 24'h061200, {r[2], r[7], r[8]});
		chk("grp_out", 19'h51200, {dp_pos, relay_first, ao_set});
		rd(8'h01, 8'h11, 5);
		chk("grp_max", 16'h8303, {r[1], r[2]});
		xact({8'h00, 8'h06, 8'h00, 8'h04, 8'h00, 8'h01}, 1'b0, 0);
		xact({sa, 8'h06, 8'h00, 8'h04, 8'h00, 8'h00}, 1'b1, 0);
		xact({8'h2B, 8'h06, 8'h00, 8'h04, 8'h00, 8'h00}, 1'b0, 0);
		chk("bcast_dp", 2'h1, dp_pos);
		xact({sa, 8'h04, 8'h00, 8'h01, 8'h00, 8'h01}, 1'b0, 5);
		chk("func_exc", 16'h8401, {r[1], r[2]});
		wp <= 1'b0;
		wr(8'h04, 16'h0000, 5);
		chk("permit", 18'h18601, {dp_pos, r[1], r[2]});
		wp <= 1'b1;
		baud <= 3'h6;
		stops <= 2'h2;
		rd(8'h04, 8'h01, 7);
		chk("slow_rd", 16'h0001, {r[3], r[4]});
		cv(1'b1, -16'sh0005, 16'h1600, lo, 5'h00, 16'h1500);
		cv(1'b0, 16'sh00C8, 16'h1000, root, 5'h09, 16'h1000);
		// Negative input without square root must not clamp; border moved
		sq <= 1'b0;
		ub <= 16'h1400;
		cv(1'b1, 16'sh0032, 16'h1500, root, 5'h05, 16'h1400);
		end_sim();
	end
	initial begin
		#7000000;
		miscompares++;
		end_sim();
	end
endmodule
